// ==== rtl/awm_cfg.svh ====
// Constants of the arbitrary waveform generator and analog output multiplexer.
// Assumes inclusion by bare name from files under rtl/.
`ifndef AWM_CFG_SVH
`define AWM_CFG_SVH

// =============================================================================
// Clock and phase slew timing
`define AWM_CLK_HZ          64'h0000_0000_0131_2D00
`define AWM_CLK_PERIOD_NS   8'h32
`define AWM_DEG_PER_TURN    64'h0000_0000_0000_0168
`define AWM_PHASE_STEPS     64'h0000_0000_0001_0000
`define AWM_SLEW_RATE_MAX   16'h03E8
// Rate accumulation needed for one phase LSB, rounded down.
`define AWM_SLEW_DIV        18'((`AWM_CLK_HZ * `AWM_DEG_PER_TURN) / `AWM_PHASE_STEPS)

// =============================================================================
// Generator limits and table geometry
`define AWM_MAX_POLE_PAIRS  7'h40
`define AWM_TBL_AW          8
`define AWM_LEVEL_MAX       16'sh7FFF
`define AWM_LEVEL_MIN       16'sh8000

// =============================================================================
// Output multiplexer
`define AWM_NUM_CH          8
`define AWM_SLAVE_CH        6
`define AWM_DIFF_CH_LO      6
`define AWM_INT_REF_MV      16'sh2710
`define AWM_DC_SHIFT        8

`endif

// ==== rtl/awm_pkg.sv ====
// Types shared by the waveform generator and output multiplexer.
// Assumes awm_cfg.svh supplies all numeric constants.
package awm_pkg;

    // =========================================================================
    // Signal and control types
    typedef logic signed [15:0] level_t;

    typedef enum logic [1:0] {
        RELAY_OPEN = 2'h0,
        RELAY_SRC  = 2'h1,
        RELAY_GND  = 2'h2,
        RELAY_REF  = 2'h3
    } relay_t;

    typedef enum logic {
        PH_LOCAL,
        PH_COMBINED
    } phase_mode_t;

endpackage : awm_pkg

// ==== rtl/awm_scale_if.sv ====
// Carries a table sample with gain and bias into the scaler, and the level back.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none

interface awm_scale_if;
    logic signed [15:0] sample;
    logic        [15:0] gain;
    logic signed [15:0] bias;
    logic signed [15:0] level;

    modport gen (output sample, output gain, output bias, input level);
    modport scl (input sample, input gain, input bias, output level);
endinterface : awm_scale_if

`default_nettype wire

// ==== rtl/awm_phase_slew.sv ====
// Moves the applied local phase toward its target at a bounded slew rate.
// Assumes target and rate come from logic on ref_clk.
`timescale 1ns/100ps
`default_nettype none
`include "awm_cfg.svh"

module awm_phase_slew (
    input  wire logic            ref_clk,
    input  wire logic            rst,
    input  wire awm_pkg::level_t target,
    input  wire logic [15:0]     rate,
    output awm_pkg::level_t      applied
);
    import awm_pkg::*;

    typedef struct packed {
        level_t      applied;
        logic [17:0] acc;
    } awm_slew_state_t;

    awm_slew_state_t q, d;
    logic [15:0]     rate_c;
    level_t          gap;
    logic [17:0]     acc_sum;

    // =========================================================================
    // Slew step: one LSB each time the rate sum passes the divider.
    always_comb begin
        d       = q;
        rate_c  = (rate > `AWM_SLEW_RATE_MAX) ? `AWM_SLEW_RATE_MAX : rate;
        gap     = target - q.applied;
        acc_sum = q.acc + {2'h0, rate_c};
        if (rate_c == 16'h0000) begin
            d.applied = target;
            d.acc     = 18'h00000;
        end else if (gap == 16'sh0000) begin
            d.acc = 18'h00000;
        end else if (acc_sum >= `AWM_SLEW_DIV) begin
            d.acc     = acc_sum - `AWM_SLEW_DIV;
            d.applied = gap[15] ? q.applied - 16'sh0001 : q.applied + 16'sh0001;
        end else begin
            d.acc = acc_sum;
        end
    end

    // State register.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign applied = q.applied;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_slew_single_step: assert property (
        $past(rate) != 16'h0000 |->
            (q.applied - $past(q.applied) == 16'sh0001) ||
            ($past(q.applied) - q.applied == 16'sh0001) || $stable(q.applied))
        else $error("applied phase moved more than one step");
    a_slew_zero_jumps: assert property (
        rate == 16'h0000 |=> q.applied == $past(target))
        else $error("zero slew rate did not jump to target");
endmodule : awm_phase_slew

`default_nettype wire

// ==== rtl/awm_scaler.sv ====
// Applies gain and bias to a table sample and clamps to the normalized range.
// Assumes the generator end drives the interface from flip-flops.
`timescale 1ns/100ps
`default_nettype none
`include "awm_cfg.svh"

module awm_scaler (
    input  wire logic ref_clk,
    input  wire logic rst,
    awm_scale_if.scl  io
);
    import awm_pkg::*;

    typedef struct packed {
        level_t level;
    } awm_scale_state_t;

    awm_scale_state_t   q, d;
    logic signed [32:0] prod;
    logic signed [17:0] sum;

    // =========================================================================
    // Full gain is 0xFFFF, a hair under one, so a full positive sample loses one LSB.
    always_comb begin
        d    = q;
        prod = 33'(io.sample) * $signed({17'h00000, io.gain});
        sum  = 18'(prod >>> 16) + 18'(io.bias);
        if (sum > 18'(`AWM_LEVEL_MAX)) begin
            d.level = `AWM_LEVEL_MAX;
        end else if (sum < 18'(`AWM_LEVEL_MIN)) begin
            d.level = `AWM_LEVEL_MIN;
        end else begin
            d.level = sum[15:0];
        end
    end

    // State register.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign io.level = q.level;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_scale_clamp_hi: assert property (
        (18'(33'(io.sample) * $signed({17'h00000, io.gain}) >>> 16) + 18'(io.bias))
            > 18'(`AWM_LEVEL_MAX) |=> io.level == `AWM_LEVEL_MAX)
        else $error("level not clamped to plus one");
    a_scale_zero_gain: assert property (
        io.gain == 16'h0000 |=> io.level == $past(io.bias))
        else $error("zero gain did not yield the bias alone");
endmodule : awm_scaler

`default_nettype wire

// ==== rtl/awm_top.sv ====
// Table-driven waveform generator paced by the mechanical angle, and an
// eight-channel analog output multiplexer with reference, mode and relay control.
// Assumes every control input comes from model logic on ref_clk.
`timescale 1ns/100ps
`default_nettype none
`include "awm_cfg.svh"

module awm_top #(
    parameter int TBL_AW = `AWM_TBL_AW
) (
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    input  wire logic                        is_master,
    input  wire awm_pkg::phase_mode_t        phase_mode,
    input  wire logic [6:0]                  pole_pairs,
    input  wire logic [15:0]                 actual_mechanical_angle,
    input  wire awm_pkg::level_t             global_angle_shift,
    input  wire awm_pkg::level_t             local_phase_shift,
    input  wire logic [15:0]                 phase_slew_rate,
    input  wire logic [15:0]                 wave_gain,
    input  wire awm_pkg::level_t             wave_bias,
    input  wire logic                        tbl_wr,
    input  wire logic [TBL_AW-1:0]           tbl_wr_addr,
    input  wire awm_pkg::level_t             tbl_wr_data,
    input  wire awm_pkg::level_t [6:0]       ext_src,
    input  wire logic [7:0][2:0]             src_sel,
    input  wire logic [7:0]                  ref_ext,
    input  wire logic                        diff_mode,
    input  wire awm_pkg::level_t             ext_ref_mv,
    input  wire logic                        relay_wr,
    input  wire logic [2:0]                  relay_wr_ch,
    input  wire awm_pkg::relay_t             relay_wr_code,
    output awm_pkg::level_t                  gen_level,
    output awm_pkg::level_t                  applied_phase,
    output awm_pkg::level_t [7:0]            ch_mv,
    output awm_pkg::relay_t [7:0]            ch_relay,
    output logic [7:0]                       ch_closed,
    output logic                             cfg_bad
);
    import awm_pkg::*;

    // =========================================================================
    // State and working signals
    typedef struct packed {
        relay_t [7:0]      relay;
        level_t [7:0]      out_mv;
        logic   [7:0]      closed;
        level_t [1:0]      dc_avg;
        level_t            sample;
        logic [TBL_AW-1:0] idx;
        logic              cfg_bad;
    } awm_top_state_t;

    awm_top_state_t q, d;
    level_t         tbl_mem [2**TBL_AW];
    level_t         mech;
    logic [6:0]     pp;
    logic [22:0]    elec;
    awm_scale_if    sc ();

    // Level times reference in millivolts; both operands are Q15 and mV.
    function automatic level_t scale_mv(input level_t lv, input level_t ref_mv);
        logic signed [31:0] p;
        p = 32'(lv) * 32'(ref_mv);
        return p[30:15];
    endfunction : scale_mv

    // Reference actually applied to a channel's converter.
    function automatic level_t chan_ref(input logic ext, input level_t ext_mv);
        return ext ? ext_mv : `AWM_INT_REF_MV;
    endfunction : chan_ref

    // =========================================================================
    // Phase slew limiter for the local shift.
    awm_phase_slew u_slew (
        .ref_clk (ref_clk),
        .rst     (rst),
        .target  (local_phase_shift),
        .rate    (phase_slew_rate),
        .applied (applied_phase)
    );

    // Gain, bias and clamp stage.
    awm_scaler u_scaler (
        .ref_clk (ref_clk),
        .rst     (rst),
        .io      (sc.scl)
    );

    assign sc.sample = q.sample;
    assign sc.gain   = wave_gain;
    assign sc.bias   = wave_bias;
    assign gen_level = sc.level;

    // =========================================================================
    // Waveform table written by the controller; no reset, contents are data.
    always_ff @(posedge ref_clk) begin
        if (tbl_wr) begin
            tbl_mem[tbl_wr_addr] <= tbl_wr_data;
        end
    end

    // Angle path: the full 16-bit angle is one turn of the table.
    always_comb begin
        pp   = (pole_pairs > `AWM_MAX_POLE_PAIRS) ? `AWM_MAX_POLE_PAIRS : pole_pairs;
        mech = actual_mechanical_angle + applied_phase;
        if (phase_mode == PH_COMBINED) begin
            mech = mech + global_angle_shift;
        end
        elec = {7'h00, mech} * {16'h0000, pp};
    end

    // =========================================================================
    // Next state: table read, relays and per-channel outputs.
    always_comb begin
        level_t src;
        level_t ref_mv;
        level_t v;
        level_t hp;
        level_t avg;
        logic   dif;
        logic signed [16:0] dlt;
        src    = '0;
        ref_mv = '0;
        v      = '0;
        hp     = '0;
        avg    = '0;
        dif    = 1'b0;
        dlt    = '0;
        d      = q;
        d.idx    = elec[15 -: TBL_AW];
        d.sample = tbl_mem[elec[15 -: TBL_AW]];
        d.cfg_bad = diff_mode && (!ref_ext[6] || !ref_ext[7]);
        if (relay_wr) begin
            d.relay[relay_wr_ch] = relay_wr_code;
        end
        for (int i = 0; i < `AWM_NUM_CH; i++) begin
            ref_mv = chan_ref(ref_ext[i], ext_ref_mv);
            src    = (src_sel[i] == 3'h0) ? gen_level : ext_src[src_sel[i] - 3'h1];
            v      = scale_mv(src, ref_mv);
            dif    = diff_mode && (i >= `AWM_DIFF_CH_LO);
            hp     = v;
            if (i >= `AWM_DIFF_CH_LO) begin
                // A slow mean follower strips the DC part in differential mode.
                avg = q.dc_avg[i % 2];
                dlt = {v[15], v} - {avg[15], avg};
                d.dc_avg[i % 2] = dif ? avg + 16'(dlt >>> `AWM_DC_SHIFT) : '0;
                hp  = dif ? 16'(dlt) : v;
            end
            d.closed[i] = 1'b1;
            case (q.relay[i])
                RELAY_OPEN: begin
                    d.out_mv[i] = '0;
                    d.closed[i] = 1'b0;
                end
                RELAY_SRC: begin
                    d.out_mv[i] = hp;
                end
                RELAY_GND: begin
                    d.out_mv[i] = '0;
                end
                RELAY_REF: begin
                    if (dif) begin
                        d.out_mv[i] = ref_ext[i] ? ext_ref_mv : '0;
                    end else begin
                        d.out_mv[i] = ref_mv;
                    end
                end
                default: begin
                    d.out_mv[i] = '0;
                    d.closed[i] = 1'b0;
                end
            endcase
            // A slave board has no channels 6 and 7.
            if (!is_master && (i >= `AWM_SLAVE_CH)) begin
                d.out_mv[i] = '0;
                d.closed[i] = 1'b0;
            end
        end
    end

    // State register; relays come out of reset open.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ch_mv     = q.out_mv;
    assign ch_relay  = q.relay;
    assign ch_closed = q.closed;
    assign cfg_bad   = q.cfg_bad;

    // =========================================================================
    // Checks on the generator and multiplexer.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_relay0_write;
        relay_wr && (relay_wr_ch == 3'h0);
    endsequence

    sequence s_relay0_taken;
        ##1 ch_relay[0] == $past(relay_wr_code);
    endsequence

    a_relay_write_taken: assert property (
        s_relay0_write |-> s_relay0_taken)
        else $error("relay code of channel 0 not taken");
    a_relay_hold_open: assert property (
        !relay_wr |=> ch_relay == $past(ch_relay))
        else $error("relay changed without a write");
    a_relay_gnd_zero: assert property (
        ch_relay[0] == RELAY_GND |=> ch_mv[0] == 16'sh0000 && ch_closed[0])
        else $error("grounded channel not at zero");
    a_ref_int_full: assert property (
        ch_relay[1] == RELAY_REF && !ref_ext[1] |=> ch_mv[1] == `AWM_INT_REF_MV)
        else $error("internal reference not at full scale");
    a_src_scaled: assert property (
        ch_relay[2] == RELAY_SRC && src_sel[2] == 3'h0 |=>
            ch_mv[2] == scale_mv($past(gen_level), chan_ref($past(ref_ext[2]),
                                                             $past(ext_ref_mv))))
        else $error("source voltage not level times reference");
    a_diff_int_zero: assert property (
        is_master && diff_mode && !ref_ext[6] && ch_relay[6] == RELAY_REF
            |=> ch_mv[6] == 16'sh0000)
        else $error("differential internal reference not zero");
    a_diff_ext_ac: assert property (
        is_master && diff_mode && ref_ext[7] && ch_relay[7] == RELAY_REF
            |=> ch_mv[7] == $past(ext_ref_mv))
        else $error("differential external reference not passed");
    a_slave_six: assert property (
        !is_master |=> ch_mv[6] == 16'sh0000 && ch_mv[7] == 16'sh0000 && ch_closed[7:6] == 2'h0)
        else $error("slave board drove channel 6 or 7");
    a_local_ignores_global: assert property (
        phase_mode == PH_LOCAL && $stable(phase_mode) && $stable(actual_mechanical_angle) &&
            $stable(applied_phase) && $stable(pole_pairs) |=> $stable(q.idx))
        else $error("global shift moved the local-only phase");
    a_combined_uses_global: assert property (
        phase_mode == PH_COMBINED && $stable(phase_mode) && pole_pairs == 7'h01 &&
            $stable(pole_pairs) && $stable(actual_mechanical_angle) &&
            $stable(applied_phase) && global_angle_shift == $past(global_angle_shift)
                + 16'sh0100 |=> q.idx == $past(q.idx) + TBL_AW'(1))
        else $error("global shift not added in combined mode");
    a_pole_pair_rate: assert property (
        pole_pairs == 7'h02 && $stable(pole_pairs) && phase_mode == PH_LOCAL &&
            $stable(phase_mode) && $stable(applied_phase) &&
            actual_mechanical_angle == $past(actual_mechanical_angle) + 16'h0080
            |=> q.idx == $past(q.idx) + TBL_AW'(1))
        else $error("table not advanced at pole pair multiple");
    a_cfg_bad_flag: assert property (
        diff_mode && !ref_ext[6] |=> cfg_bad)
        else $error("invalid reference and mode not flagged");
endmodule : awm_top

`default_nettype wire

// ==== tb/awm_rpm_model.sv ====
// Angle source and pole-pair setting that stand in front of the generator.
// Assumes the bench drives its requests on ref_clk edges.
`timescale 1ns/100ps
`default_nettype none

module awm_rpm_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        load,
    input  wire logic [15:0] load_angle,
    input  wire logic [15:0] step,
    input  wire logic [6:0]  pp_req,
    output logic [15:0]      actual_mechanical_angle,
    output logic [6:0]       pole_pairs
);
    // =========================================================================
    // Angle ramp
    // The angle wraps once per turn, or is parked at a loaded value.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            actual_mechanical_angle <= 16'h0000;
        else if (load)
            actual_mechanical_angle <= load_angle;
        else
            actual_mechanical_angle <= actual_mechanical_angle + step;
    end

    // Never hand over more than sixty-four pole pairs, nor zero.
    assign pole_pairs = (pp_req > 7'h40) ? 7'h40 : ((pp_req == 7'h00) ? 7'h01 : pp_req);
endmodule : awm_rpm_model

`default_nettype wire

// ==== tb/tb_awm_top.sv ====
// Self-checking bench of the waveform generator and output multiplexer.
// Assumes the angle model above and a 20 MHz ref_clk.
`timescale 1ns/100ps
`default_nettype none

module tb_awm_top;
    import awm_pkg::*;
    logic            ref_clk, rst, is_master, tbl_wr, diff_mode, relay_wr, ld, cfg_bad;
    phase_mode_t     phase_mode;
    logic [6:0]      pp_req, pole_pairs;
    logic [15:0]     ld_ang, step, actual_mechanical_angle, phase_slew_rate, wave_gain;
    level_t          global_angle_shift, local_phase_shift, wave_bias, tbl_wr_data;
    level_t          ext_ref_mv, gen_level, applied_phase;
    logic [7:0]      tbl_wr_addr, ref_ext, ch_closed;
    level_t [6:0]    ext_src;
    logic [7:0][2:0] src_sel;
    logic [2:0]      relay_wr_ch;
    relay_t          relay_wr_code;
    level_t [7:0]    ch_mv;
    relay_t [7:0]    ch_relay;
    level_t          tbl [256];
    int              mismatches, cmp_count;

    awm_rpm_model i_awm_rpm_model (.ref_clk, .rst, .load(ld), .load_angle(ld_ang), .step,
        .pp_req, .actual_mechanical_angle, .pole_pairs);

    awm_top i_awm_top (.ref_clk, .rst, .is_master, .phase_mode, .pole_pairs,
        .actual_mechanical_angle, .global_angle_shift, .local_phase_shift, .phase_slew_rate,
        .wave_gain, .wave_bias, .tbl_wr, .tbl_wr_addr, .tbl_wr_data, .ext_src, .src_sel,
        .ref_ext, .diff_mode, .ext_ref_mv, .relay_wr, .relay_wr_ch, .relay_wr_code,
        .gen_level, .applied_phase, .ch_mv, .ch_relay, .ch_closed, .cfg_bad);

    // =========================================================================
    // Clock and expectations
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Scaled and clamped level; wide sum so that overflow cannot wrap.
    function automatic level_t f_lvl(level_t t, logic [15:0] g, level_t b);
        logic signed [33:0] s;
        s = ((34'(t) * $signed({18'h00000, g})) >>> 16) + 34'(b);
        if (s > 34'sh7FFF) return 16'sh7FFF;
        if (s < -34'sh8000) return 16'sh8000;
        return s[15:0];
    endfunction : f_lvl

    function automatic level_t f_mv(level_t v, level_t r);
        logic signed [31:0] p;
        p = (32'(v) * 32'(r)) >>> 15;
        return p[15:0];
    endfunction : f_mv

    function automatic logic [7:0] f_idx(logic [15:0] a, level_t l, level_t g,
                                         phase_mode_t m, logic [6:0] n);
        logic [15:0] s;
        s = a + l + ((m == PH_COMBINED) ? g : 16'sh0000);
        s = s * 16'(n);
        return s[15:8];
    endfunction : f_idx

    // =========================================================================
    // Comparison, relay write and closing tasks
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_rng(string nm, level_t v, int lo, int hi);
        cmp_count++;
        if ($isunknown(v) || !(v >= lo && v <= hi)) begin
            mismatches++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, v);
        end
    endtask : chk_rng

    task automatic cyc(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic wr_relay(int c, relay_t k);
        @(posedge ref_clk);
        relay_wr <= 1'b1;
        relay_wr_ch <= 3'(c);
        relay_wr_code <= k;
        @(posedge ref_clk);
        relay_wr <= 1'b0;
        cyc(3);
    endtask : wr_relay

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    // A hang is cut short well beyond the roughly 7050 cycles of the run.
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        tally_and_finish();
    end

    // =========================================================================
    // Main sequence
    initial begin
        int i, c, k;
        level_t e, r, v, lastl, keep;
        {rst, is_master} = 2'h3;
        {tbl_wr, diff_mode, relay_wr, ld, ref_ext, tbl_wr_addr} = 20'h00000;
        {pp_req, ld_ang, step, phase_slew_rate, wave_gain} = 71'h0;
        {global_angle_shift, local_phase_shift, wave_bias, tbl_wr_data, ext_ref_mv} = 80'h0;
        {ext_src, src_sel, relay_wr_ch} = 139'h0;
        phase_mode = PH_LOCAL;
        relay_wr_code = RELAY_OPEN;
        void'($urandom(62));
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        cyc(2);
        for (i = 0; i < 8; i++) chk("ch_relay", 16'(RELAY_OPEN), 16'(ch_relay[i]));
        chk("ch_closed", 16'h0000, 16'(ch_closed));
        // Table filled back to back; the first entries hold full-scale corners.
        for (i = 0; i < 256; i++) begin
            @(posedge ref_clk);
            tbl[i] = (i < 4) ? (i[0] ? 16'sh7FFF : 16'sh8000) : level_t'($urandom);
            tbl_wr <= 1'b1;
            tbl_wr_addr <= 8'(i);
            tbl_wr_data <= tbl[i];
        end
        @(posedge ref_clk);
        tbl_wr <= 1'b0;
        ld <= 1'b1;
        // Parked angles; the first two drive the clamp to each rail.
        for (i = 0; i < 48; i++) begin
            @(posedge ref_clk);
            ld_ang <= (i < 2) ? 16'h0100 << i : 16'($urandom);
            pp_req <= (i < 2) ? 7'h01 : 7'($urandom_range(64, 1));
            local_phase_shift <= (i < 2) ? 16'sh0000 : level_t'($urandom);
            global_angle_shift <= level_t'($urandom);
            phase_mode <= phase_mode_t'(i[0] & (i > 1));
            wave_gain <= (i < 4) ? 16'hFFFF : 16'($urandom);
            wave_bias <= (i < 2) ? (i[0] ? 16'sh8000 : 16'sh7FFF) : level_t'($urandom);
            cyc(6);
            e = f_lvl(tbl[f_idx(actual_mechanical_angle, local_phase_shift, global_angle_shift,
                                phase_mode, pole_pairs)], wave_gain, wave_bias);
            chk("applied_phase", local_phase_shift, applied_phase);
            chk("gen_level", e, gen_level);
        end
        lastl = e;
        keep = local_phase_shift;
        // Slewing: a quarter-turn request must crawl, not jump.
        @(posedge ref_clk);
        local_phase_shift <= 16'sh0000;
        cyc(3);
        @(posedge ref_clk);
        phase_slew_rate <= 16'h03E8;
        local_phase_shift <= 16'sh4000;
        cyc(1100);
        chk_rng("applied_phase", applied_phase, 8, 11);
        @(posedge ref_clk);
        phase_slew_rate <= 16'hFFFF;
        local_phase_shift <= -16'sh0100;
        cyc(1100);
        chk_rng("applied_phase", applied_phase, -3, 3);
        @(posedge ref_clk);
        phase_slew_rate <= 16'h0000;
        local_phase_shift <= keep;
        cyc(4);
        chk("gen_level", lastl, gen_level);
        // Every relay code on every channel with random references, and random sources except the generator on channels 0 and 2.
        for (c = 0; c < 8; c++) for (k = 0; k < 4; k++) begin
            @(posedge ref_clk);
            ext_src <= 112'({$urandom, $urandom, $urandom, $urandom});
            src_sel[c] <= (c == 0 || c == 2) ? 3'h0 : 3'($urandom_range(7, 1));
            ref_ext[c] <= 1'($urandom);
            ext_ref_mv <= level_t'($urandom);
            wr_relay(c, relay_t'(k));
            r = ref_ext[c] ? ext_ref_mv : 16'sh2710;
            v = (src_sel[c] == 3'h0) ? lastl : ext_src[src_sel[c] - 3'h1];
            e = (k == 1) ? f_mv(v, r) : ((k == 3) ? r : 16'sh0000);
            chk("ch_mv", e, ch_mv[c]);
            chk("ch_closed", 16'(k != 0), 16'(ch_closed[c]));
            chk("ch_relay", 16'(k), 16'(ch_relay[c]));
        end
        @(posedge ref_clk);
        is_master <= 1'b0;
        cyc(3);
        chk("ch_mv6", 16'h0000, ch_mv[6]);
        chk("ch_closed", 16'h003F, 16'(ch_closed));
        // Differential pair on an external reference, then a bad internal one.
        @(posedge ref_clk);
        {is_master, diff_mode, ref_ext} <= 10'h3C0;
        ext_ref_mv <= 16'sh2710;
        cyc(3);
        chk("ch_mv6", 16'sh2710, ch_mv[6]);
        chk("cfg_bad", 16'h0000, 16'(cfg_bad));
        @(posedge ref_clk);
        ref_ext[6] <= 1'b0;
        cyc(3);
        chk("cfg_bad", 16'h0001, 16'(cfg_bad));
        chk("ch_mv6", 16'h0000, ch_mv[6]);
        @(posedge ref_clk);
        ref_ext[6] <= 1'b1;
        ext_src[0] <= 16'sh4000;
        src_sel[7] <= 3'h1;
        src_sel[5] <= 3'h1;
        wr_relay(5, RELAY_SRC);
        wr_relay(7, RELAY_SRC);
        cyc(4000);
        chk("ch_mv5", f_mv(16'sh4000, 16'sh2710), ch_mv[5]);
        chk_rng("ch_mv7", ch_mv[7], -300, 300);
        // Phase path corners: one global step at one pole pair in combined mode, then one in local mode at two, then an angle ramp at two.
        @(posedge ref_clk);
        pp_req <= 7'h01;
        cyc(3);
        @(posedge ref_clk);
        global_angle_shift <= global_angle_shift + 16'sh0100;
        cyc(3);
        @(posedge ref_clk);
        pp_req <= 7'h02;
        phase_mode <= PH_LOCAL;
        cyc(3);
        @(posedge ref_clk);
        global_angle_shift <= global_angle_shift + 16'sh0100;
        cyc(3);
        @(posedge ref_clk);
        step <= 16'h0080;
        ld <= 1'b0;
        cyc(3);
        tally_and_finish();
    end
endmodule : tb_awm_top

`default_nettype wire
